/* File: core/asp_ctrl.sv */
// Purpose: Converter control: frame sequencing, power modes, data pin
// Assumes: Serial clock high time spans at least two system clocks
// Notes:   Link logic runs on the serial clock, decisions on clk_i
`timescale 1ns/10ps
`default_nettype none
module asp_ctrl #(
  parameter int unsigned RES_BITS = asp_pkg::FULL_RES
) (
  input  wire logic                clk_i,
  input  wire logic                arst_n_i,
  input  wire logic                sclk_i,
  input  wire logic                select_n_i,
  input  wire logic [RES_BITS-1:0] result_i,
  output logic                     serial_data_out_o,
  output logic                     serial_data_oe_o,
  output logic                     hold_o,
  output logic                     conv_start_o,
  output logic                     analog_on_o,
  output logic                     powered_o,
  output logic                     dummy_o
);
  // ****************************************************
  // Link side
  // ****************************************************
  logic                       link_rst_n;
  logic [asp_pkg::FLG_N-1:0]  flag_l;

  // Select high clears the whole link side
  assign link_rst_n = arst_n_i & ~select_n_i;

  asp_link #(
    .RES_BITS     (RES_BITS)
  ) u_link (
    .sclk_i       (sclk_i),
    .link_rst_n_i (link_rst_n),
    .result_i     (result_i),
    .data_o       (serial_data_out_o),
    .flag_o       (flag_l)
  );

  // ****************************************************
  // Crossing to the system clock
  // ****************************************************
  logic                       sel_s;
  logic                       sel_prev_q;
  logic [asp_pkg::FLG_N-1:0]  flag_s;

  asp_sync #(
    .W        (1),
    .RST      (1'b1)
  ) u_sel_sync (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .d_i      (select_n_i),
    .q_o      (sel_s)
  );

  asp_sync #(
    .W        (asp_pkg::FLG_N),
    .RST      ('0)
  ) u_flag_sync (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .d_i      (flag_l),
    .q_o      (flag_s)
  );

  logic sel_fall;
  logic sel_rise;

  assign sel_fall = sel_prev_q & ~sel_s;
  assign sel_rise = ~sel_prev_q & sel_s;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sel_prev_q <= 1'b1;
    end else begin
      sel_prev_q <= sel_s;
    end
  end

  // ****************************************************
  // Milestones seen in the current frame
  // ****************************************************
  logic [asp_pkg::FLG_N-1:0] seen_q;
  logic [asp_pkg::FLG_N-1:0] seen_now;

  assign seen_now = seen_q | flag_s;

  // Kept up to the rise for the decision, then dropped so no stale milestone
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      seen_q <= '0;
    end else if (sel_fall || sel_rise) begin
      seen_q <= '0;
    end else if (!sel_s) begin
      seen_q <= seen_now;
    end
  end

  // ****************************************************
  // Power mode
  // ****************************************************
  asp_pkg::asp_mode_t mode_q;
  asp_pkg::asp_mode_t mode_d;

  always_comb begin
    mode_d = mode_q;
    unique case (mode_q)
      asp_pkg::ASP_NORMAL: begin
        if (sel_rise && seen_now[asp_pkg::FLG_PD] &&
            !seen_now[asp_pkg::FLG_NORM]) begin
          mode_d = asp_pkg::ASP_DOWN;
        end
      end
      asp_pkg::ASP_DOWN: begin
        if (sel_fall) begin
          mode_d = asp_pkg::ASP_WAKING;
        end
      end
      asp_pkg::ASP_WAKING: begin
        if (sel_rise) begin
          if (seen_now[asp_pkg::FLG_NORM]) begin
            mode_d = asp_pkg::ASP_NORMAL;
          end else begin
            mode_d = asp_pkg::ASP_DOWN;
          end
        end else if (seen_now[asp_pkg::FLG_END]) begin
          mode_d = asp_pkg::ASP_NORMAL;
        end
      end
    endcase
  end

  // Early rise keeps normal mode since no transition fires
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_q <= asp_pkg::ASP_NORMAL;
    end else begin
      mode_q <= mode_d;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      analog_on_o <= 1'b1;
      powered_o   <= 1'b1;
    end else begin
      analog_on_o <= mode_d != asp_pkg::ASP_DOWN;
      powered_o   <= mode_d == asp_pkg::ASP_NORMAL;
    end
  end

  // Frame started while asleep is a dummy; its word is not valid
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dummy_o <= 1'b0;
    end else if (sel_fall) begin
      dummy_o <= mode_q == asp_pkg::ASP_DOWN;
    end
  end

  // ****************************************************
  // Frame strobes and data pin enable
  // ****************************************************
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      conv_start_o <= 1'b0;
    end else begin
      conv_start_o <= sel_fall;
    end
  end

  // Hold from select fall until the track point
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hold_o <= 1'b0;
    end else begin
      hold_o <= !sel_s && !seen_now[asp_pkg::FLG_TRACK];
    end
  end

  // Released at the sixteenth fall or any select rise
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      serial_data_oe_o <= 1'b0;
    end else begin
      serial_data_oe_o <= !sel_s && !seen_now[asp_pkg::FLG_END];
    end
  end

  // ****************************************************
  // Checks
  // ****************************************************
  sequence s_frame_open;
    sel_fall ##1 (conv_start_o && serial_data_oe_o && hold_o);
  endsequence

  sequence s_early_rise;
    sel_rise && !seen_now[asp_pkg::FLG_PD];
  endsequence

  a_frame_open: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    sel_fall && !seen_now[asp_pkg::FLG_END] |-> s_frame_open)
    else $error("frame start not seen on outputs");
  a_abort_powered: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    sel_rise && mode_q == asp_pkg::ASP_NORMAL && seen_now[asp_pkg::FLG_NORM]
    |=> mode_q == asp_pkg::ASP_NORMAL && !serial_data_oe_o)
    else $error("late abort changed power");
  a_pd_enter: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    sel_rise && mode_q == asp_pkg::ASP_NORMAL && seen_now[asp_pkg::FLG_PD]
    && !seen_now[asp_pkg::FLG_NORM]
    |=> mode_q == asp_pkg::ASP_DOWN ##1 !analog_on_o)
    else $error("power-down window missed");
  a_glitch_keep: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    s_early_rise and (mode_q == asp_pkg::ASP_NORMAL)
    |=> mode_q == asp_pkg::ASP_NORMAL)
    else $error("early rise powered down");
  a_down_off: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    mode_q == asp_pkg::ASP_DOWN && $stable(mode_q) |-> !analog_on_o)
    else $error("analog on in power-down");
  a_wake_start: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    sel_fall && mode_q == asp_pkg::ASP_DOWN
    |=> mode_q == asp_pkg::ASP_WAKING ##1 analog_on_o && dummy_o)
    else $error("dummy frame did not start power-up");
  a_wake_done: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    mode_q == asp_pkg::ASP_WAKING && seen_now[asp_pkg::FLG_END]
    |=> mode_q == asp_pkg::ASP_NORMAL ##1 powered_o)
    else $error("not powered after sixteen clocks");
  a_wake_abort: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    sel_rise && mode_q == asp_pkg::ASP_WAKING && !seen_now[asp_pkg::FLG_NORM]
    |=> mode_q == asp_pkg::ASP_DOWN)
    else $error("short dummy frame did not sleep");
  a_data_release: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    seen_now[asp_pkg::FLG_END] |=> !serial_data_oe_o [*2])
    else $error("data line not released");
endmodule : asp_ctrl
`default_nettype wire

/* File: core/asp_pkg.sv */
// Purpose: Shared constants and types for the serial converter control
// Assumes: Select and serial clock come from the host
// Notes:   Counts are serial clock falling edges since select fell
// Function
// - Select falling edge samples the input and starts a conversion.
// - Select rising between falls ten and sixteen aborts, stays powered, releases data.
// - Rise in power-down window powers down, aborts, releases data line.
// - Rise before the second fall keeps normal mode.
// - Power-down switches all analog circuitry off.
// - Dummy conversion wakes; powering up from select fall past tenth fall.
// - Fully powered after sixteen dummy clocks; next conversion valid.
// - Waking rise before tenth fall returns to power-down.
// - Word is four zeros, result MSB first, zero padded to sixteen.
// - First zero at select fall, later bits on falling edges.
// - Track after thirteen falls at next rise; release at sixteenth fall.
package asp_pkg;
  localparam int unsigned WORD_W    = 16;
  localparam int unsigned FULL_RES  = 12;
  localparam int unsigned CNT_W     = 5;
  localparam logic [4:0]  CNT_LEAD  = 5'h04;
  localparam logic [4:0]  CNT_PD    = 5'h02;
  localparam logic [4:0]  CNT_NORM  = 5'h0a;
  localparam logic [4:0]  CNT_TRACK = 5'h0d;
  localparam logic [4:0]  CNT_END   = 5'h10;
  // Milestone flag positions
  localparam int unsigned FLG_N     = 4;
  localparam int unsigned FLG_PD    = 0;
  localparam int unsigned FLG_NORM  = 1;
  localparam int unsigned FLG_END   = 2;
  localparam int unsigned FLG_TRACK = 3;

  typedef enum logic [1:0] {
    ASP_NORMAL,
    ASP_DOWN,
    ASP_WAKING
  } asp_mode_t;
endpackage : asp_pkg

/* File: core/asp_sync.sv */
// Purpose: Two flip-flop level synchroniser
// Assumes: Each bit is an independent level
// Notes:   First stage is read only by the second
`timescale 1ns/10ps
`default_nettype none
module asp_sync #(
  parameter int unsigned        W   = 1,
  parameter logic [W-1:0]       RST = '0
) (
  input  wire logic         clk_i,
  input  wire logic         arst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_q <= RST;
      q_o    <= RST;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule : asp_sync
`default_nettype wire

/* File: core/asp_link.sv */
// Purpose: Serial clock side: edge count, milestones, data shifter
// Assumes: Held in reset while select is high
// Notes:   Milestone flags are monotonic levels within a frame
`timescale 1ns/10ps
`default_nettype none
module asp_link #(
  parameter int unsigned RES_BITS = asp_pkg::FULL_RES
) (
  input  wire logic                          sclk_i,
  input  wire logic                          link_rst_n_i,
  input  wire logic [RES_BITS-1:0]           result_i,
  output logic                               data_o,
  output logic [asp_pkg::FLG_N-1:0]          flag_o
);
  logic [asp_pkg::CNT_W-1:0]  cnt_q;
  logic [asp_pkg::CNT_W-1:0]  cnt_nx;
  logic [asp_pkg::FULL_RES-1:0] res_al;
  logic [asp_pkg::WORD_W-1:0] word;
  logic [asp_pkg::CNT_W-1:0]  bit_idx;
  logic [asp_pkg::FLG_N-2:0]  mile_q;
  logic                       track_q;

  // One driver per flag group; track runs on the opposite edge
  assign flag_o = {track_q, mile_q};

  assign res_al  = asp_pkg::FULL_RES'(result_i)
                   << (asp_pkg::FULL_RES - RES_BITS);
  assign word    = {{(asp_pkg::WORD_W - asp_pkg::FULL_RES){1'b0}},
                    res_al};
  assign cnt_nx  = (cnt_q == asp_pkg::CNT_END) ? cnt_q : cnt_q + 5'h01;
  assign bit_idx = 5'(asp_pkg::WORD_W - 2) - cnt_q;

  // Falls counted from zero each frame
  always_ff @(negedge sclk_i or negedge link_rst_n_i) begin
    if (!link_rst_n_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_nx;
    end
  end

  // Leading zero held from select fall, next bit per fall
  always_ff @(negedge sclk_i or negedge link_rst_n_i) begin
    if (!link_rst_n_i) begin
      data_o <= 1'b0;
    end else if (cnt_nx < asp_pkg::CNT_END) begin
      data_o <= word[bit_idx[3:0]];
    end else begin
      data_o <= 1'b0;
    end
  end

  always_ff @(negedge sclk_i or negedge link_rst_n_i) begin
    if (!link_rst_n_i) begin
      mile_q <= '0;
    end else begin
      mile_q[asp_pkg::FLG_PD]   <= cnt_nx >= asp_pkg::CNT_PD;
      mile_q[asp_pkg::FLG_NORM] <= cnt_nx >= asp_pkg::CNT_NORM;
      mile_q[asp_pkg::FLG_END]  <= cnt_nx >= asp_pkg::CNT_END;
    end
  end

  // Back to track on the rise after thirteen falls
  always_ff @(posedge sclk_i or negedge link_rst_n_i) begin
    if (!link_rst_n_i) begin
      track_q <= 1'b0;
    end else begin
      track_q <= cnt_q >= asp_pkg::CNT_TRACK;
    end
  end

  a_lead_zeros: assert property (@(negedge sclk_i) disable iff (!link_rst_n_i)
    (cnt_q < asp_pkg::CNT_LEAD) |-> !data_o)
    else $error("leading zero not driven");
  a_count_sat: assert property (@(negedge sclk_i) disable iff (!link_rst_n_i)
    cnt_q <= asp_pkg::CNT_END)
    else $error("edge count past sixteen");
endmodule : asp_link
`default_nettype wire

/* File: dv/asp_host.sv */
// Purpose: Host serial master model driving select and serial clock
// Assumes: Serial clock idles high and stands still between frames
// Notes:   The bench reads the captured word and samples by name
`timescale 1ns/10ps
`default_nettype none
module asp_host (
  input  wire logic clk_i,
  input  wire logic pin_i,
  input  wire logic oe_i,
  input  wire logic hold_i,
  input  wire logic analog_on_i,
  output logic      select_n_o,
  output logic      sclk_o
);
  // ****
  // Frame driver
  // ****
  logic [15:0] word;
  logic        oe_mid;
  logic        hold_mid;
  logic        an_mid;
  logic        oe_end;
  logic        hold_end;

  initial begin
    select_n_o = 1'b1;
    sclk_o     = 1'b1;
  end

  task automatic frame(input int n);
    word = '0;
    @(negedge clk_i);
    select_n_o = 1'b0;
    #207;
    oe_mid   = oe_i;
    hold_mid = hold_i;
    an_mid   = analog_on_i;
    for (int i = 0; i < n; i++) begin
      word[15-i] = pin_i;
      sclk_o     = 1'b0;
      #80;
      sclk_o = 1'b1;
      #80;
    end
    #200;
    oe_end   = oe_i;
    hold_end = hold_i;
    @(negedge clk_i);
    select_n_o = 1'b1;
    #400;
  endtask : frame
endmodule : asp_host
`default_nettype wire

/* File: dv/asp_ctrl_tb.sv */
// Purpose: Self-checking bench for the converter control
// Assumes: Host model drives select and serial clock
// Notes:   Mode model kept as an integer per frame
`timescale 1ns/10ps
`default_nettype none
module asp_ctrl_tb;
  // ****
  // Bench
  // ****
  localparam int RB = 10;
  logic          clk_i;
  logic          arst_n_i;
  logic          select_n;
  logic          sclk;
  logic          data;
  logic          oe;
  logic          hold;
  logic          cs;
  logic          an;
  logic          pw;
  logic          dm;
  logic [RB-1:0] res;
  wire logic     pin = oe ? data : ~data;
  int            n_mismatch;
  int            checks;
  int            seed;
  int            mode;
  int            n_cs;
  int            seq[$] = '{16, 16, 1, 0, 5, 4, 16, 16, 12, 9, 12, 16,
                            2, 16, 10, 16, 3, 9, 16};

  asp_ctrl #(.RES_BITS(RB)) asp_ctrl_i (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .sclk_i(sclk),
    .select_n_i(select_n), .result_i(res),
    .serial_data_out_o(data), .serial_data_oe_o(oe), .hold_o(hold),
    .conv_start_o(cs), .analog_on_o(an), .powered_o(pw), .dummy_o(dm)
  );

  asp_host asp_host_i (
    .clk_i(clk_i), .pin_i(pin), .oe_i(oe), .hold_i(hold),
    .analog_on_i(an), .select_n_o(select_n), .sclk_o(sclk)
  );

  initial clk_i = 1'b0;
  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) if (cs === 1'b1) n_cs++;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic run(input int n);
    logic [15:0] w;
    int          dmy;
    int          cs0;
    @(negedge clk_i);
    res  = RB'($random(seed));
    w    = 16'(res) << (12 - RB);
    dmy  = (mode == 1);
    cs0  = n_cs;
    if (mode == 1) mode = 2;
    asp_host_i.frame(n);
    if (mode == 0 && n >= 2 && n < 10) mode = 1;
    else if (mode == 2) mode = (n < 10) ? 1 : 0;
    chk(16'(n_cs - cs0), 16'h0001);
    chk(asp_host_i.oe_mid, 1'b1);
    chk(asp_host_i.an_mid, 1'b1);
    chk(asp_host_i.oe_end, n < 16);
    if (!dmy) chk(asp_host_i.hold_mid, 1'b1);
    if (!dmy) chk(asp_host_i.hold_end, n < 13);
    if (n == 16 && !dmy) chk(asp_host_i.word, w);
    chk(oe, 1'b0);
    chk(data, 1'b0);
    chk(an, mode != 1);
    chk(pw, mode == 0);
    chk(dm, dmy[0]);
    $display("test n=%0d mode=%0d done", n, mode);
  endtask : run

  task automatic give_verdict();
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  initial begin
    seed       = 4691;
    mode       = 0;
    n_mismatch = 0;
    checks     = 0;
    n_cs       = 0;
    arst_n_i   = 1'b0;
    res        = '0;
    repeat (12) @(negedge clk_i);
    arst_n_i = 1'b1;
    repeat (3) @(negedge clk_i);
    chk({oe, an, pw, dm}, 16'h0006);
    foreach (seq[i]) run(seq[i]);
    repeat (8) run($unsigned($random(seed)) % 17);
    give_verdict();
  end

  initial begin
    #500000;
    n_mismatch++;
    give_verdict();
  end
endmodule : asp_ctrl_tb
`default_nettype wire
